// >>> design/elec_pkg.sv
// Constants shared by the enclave leaf entry checker: register map,
// field positions, write masks, opcodes, leaf numbers and outcomes.
// Assumes a 32-bit APB with word-aligned registers.
package elec_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_MODE_STATE  = 12'h000;
  localparam logic [11:0] OFS_CAPS        = 12'h004;
  localparam logic [11:0] OFS_FEATURE_CTL = 12'h008;
  localparam logic [11:0] OFS_LEAF_LO     = 12'h00c;
  localparam logic [11:0] OFS_LEAF_HI     = 12'h010;
  localparam logic [11:0] OFS_BITMAP_LO   = 12'h014;
  localparam logic [11:0] OFS_BITMAP_HI   = 12'h018;
  localparam logic [11:0] OFS_ISSUE       = 12'h01c;
  localparam logic [11:0] OFS_RESULT      = 12'h020;

  // Mode state register fields
  localparam int MB_PROT     = 0;
  localparam int MB_PAGING   = 1;
  localparam int MB_NATFP    = 2;
  localparam int MB_TSW      = 3;
  localparam int MB_V86      = 4;
  localparam int MB_SYSMGMT  = 5;
  localparam int MB_LMA      = 6;
  localparam int MB_CSL      = 7;
  localparam int MB_CSD      = 8;
  localparam int MB_DS_EXPDN = 9;
  localparam int MB_INENCL   = 10;
  localparam int MB_VMXOP    = 11;
  localparam int MB_NONROOT  = 12;
  localparam int MB_HV_CTL   = 13;
  localparam int MB_TXACT    = 14;
  localparam int MB_PRIV_LO  = 16;
  localparam int MB_BT_U_EN  = 18;
  localparam int MB_BT_S_EN  = 19;
  localparam int MB_TRK_U    = 20;
  localparam int MB_TRK_S    = 21;
  localparam logic [31:0] MODE_MASK = 32'h003f_7fff;

  // Capability and feature-control fields
  localparam int CB_BASIC = 0;
  localparam int CB_OVERSUB = 5;
  localparam logic [31:0] CAPS_MASK = 32'h0000_0021;
  localparam int FB_LOCK = 0;
  localparam int FB_ENABLE = 1;
  localparam logic [31:0] FEAT_MASK = 32'h0000_0003;

  // Issue register fields
  localparam int IB_LOCK = 24;
  localparam int IB_OPSIZE = 25;
  localparam int IB_REP = 26;
  localparam int IB_VEX = 27;
  localparam int IB_SEGOVR = 28;
  localparam int IB_ADDRSZ = 29;
  localparam int IB_REX = 30;
  localparam logic [23:0] USER_OPCODE = 24'h0f_01d7;
  localparam logic [23:0] HYP_OPCODE  = 24'h0f_01c0;

  // Leaf numbers and counts
  localparam logic [31:0] LEAF_REPORT  = 32'h0000_0000;
  localparam logic [31:0] LEAF_KEY     = 32'h0000_0001;
  localparam logic [31:0] LEAF_ENTRY   = 32'h0000_0002;
  localparam logic [31:0] LEAF_RESUME  = 32'h0000_0003;
  localparam logic [31:0] LEAF_EXIT    = 32'h0000_0004;
  localparam logic [31:0] LEAF_ACCEPT  = 32'h0000_0005;
  localparam logic [31:0] LEAF_PEXTEND = 32'h0000_0006;
  localparam logic [31:0] LEAF_ACOPY   = 32'h0000_0007;
  localparam logic [31:0] USER_LEAF_COUNT = 32'h0000_0008;
  localparam logic [31:0] HYP_LEAF_COUNT  = 32'h0000_0003;
  localparam logic [31:0] BITMAP_LAST_LEAF = 32'h0000_003e;
  localparam logic [1:0]  PRIV_USER = 2'h3;
  localparam logic [1:0]  PRIV_KERNEL = 2'h0;
  localparam logic [15:0] GP_ERROR_CODE = 16'h0000;

  typedef enum logic [3:0] {
    OUT_IDLE, OUT_LEAF_FLOW, OUT_TX_ABORT, OUT_UD, OUT_NM,
    OUT_GP, OUT_CP, OUT_VM_EXIT, OUT_NOT_MINE
  } elec_outcome_t;

endpackage

// >>> design/elec_top.sv
// Entry checker for the user and hypervisor enclave instructions.
// Assumes an APB master on pclk; issue is posted by a write to the issue register.
// What this block does
// - Decode user opcode; leaf from low accumulator half
// - User op undefined without protection, v86, sysmgmt
// - User op below privilege three is undefined
// - User op faults GP on paging, FP-error, leaf
// - Task-switched bit gives device-not-available fault on user op
// - Wide addressing only in 64-bit mode
// - Segment, address-size, register-extension prefixes ignored
// - Lock, opsize, repeat, vector prefixes are undefined
// - User checks follow fixed order, bad prefix first, then abort
// - Feature lock or enable clear gives GP(0)
// - Wide mode is LMA AND CS.L; 16-bit user op faults
// - Inside enclave, entry or resume leaf faults
// - Outside enclave, in-enclave leaves fault
// - Branch tracker awaiting marker flags violation on user op
// - Basic capability clear makes user op undefined
// - Hypervisor op needs VMX, 64-bit code if long
// - Hypervisor op only at privilege zero
// - Guest hypervisor op exits per bitmap or undefined
// - Hypervisor op GP on paging, leaf, expand-down
// - Oversubscription capability clear makes hypervisor op undefined
// - Hypervisor op unrecognised in real and v86
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
module elec_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  outcome,
  output logic             outcome_valid,
  output logic             leaf_flow_go,
  output logic      [31:0] leaf_index,
  output logic             tx_abort,
  output logic             branch_violation,
  output logic             vm_exit
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb,
                                              input logic [31:0] mask);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  logic [31:0] mode_reg;
  logic [31:0] caps_reg;
  logic [31:0] feat_reg;
  logic [31:0] leaf_lo_reg;
  logic [31:0] leaf_hi_reg;
  logic [31:0] bitmap_lo_reg;
  logic [31:0] bitmap_hi_reg;
  logic [31:0] result_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [3:0]  outcome_reg;
  logic        outcome_valid_reg;
  logic        leaf_flow_go_reg;
  logic [31:0] leaf_index_reg;
  logic        tx_abort_reg;
  logic        branch_violation_reg;
  logic        vm_exit_reg;

  // Bus decode: one wait state, write lands at the completing edge
  wire         access_start = psel & penable & ~pready_reg;
  wire         access_done  = psel & penable & pready_reg;
  wire         wr_done      = access_done & pwrite;
  wire         sel_mode     = paddr == elec_pkg::OFS_MODE_STATE;
  wire         sel_caps     = paddr == elec_pkg::OFS_CAPS;
  wire         sel_feat     = paddr == elec_pkg::OFS_FEATURE_CTL;
  wire         sel_leaf_lo  = paddr == elec_pkg::OFS_LEAF_LO;
  wire         sel_leaf_hi  = paddr == elec_pkg::OFS_LEAF_HI;
  wire         sel_bm_lo    = paddr == elec_pkg::OFS_BITMAP_LO;
  wire         sel_bm_hi    = paddr == elec_pkg::OFS_BITMAP_HI;
  wire         sel_issue    = paddr == elec_pkg::OFS_ISSUE;
  wire         sel_result   = paddr == elec_pkg::OFS_RESULT;
  wire         mapped       = sel_mode | sel_caps | sel_feat | sel_leaf_lo | sel_leaf_hi |
                              sel_bm_lo | sel_bm_hi | sel_issue | sel_result;
  wire         issue_fire   = wr_done & sel_issue & (&pstrb);
  wire [31:0]  read_mux     = sel_mode    ? mode_reg      :
                              sel_caps    ? caps_reg      :
                              sel_feat    ? feat_reg      :
                              sel_leaf_lo ? leaf_lo_reg   :
                              sel_leaf_hi ? leaf_hi_reg   :
                              sel_bm_lo   ? bitmap_lo_reg :
                              sel_bm_hi   ? bitmap_hi_reg :
                              sel_result  ? result_reg    : 32'h0000_0000;

  // Processor state view
  wire         prot_on      = mode_reg[elec_pkg::MB_PROT];
  wire         paging_on    = mode_reg[elec_pkg::MB_PAGING];
  wire         native_fp_on = mode_reg[elec_pkg::MB_NATFP];
  wire         task_sw      = mode_reg[elec_pkg::MB_TSW];
  wire         v86_mode     = mode_reg[elec_pkg::MB_V86];
  wire         sys_mgmt     = mode_reg[elec_pkg::MB_SYSMGMT];
  wire         lma          = mode_reg[elec_pkg::MB_LMA];
  wire         cs_long      = mode_reg[elec_pkg::MB_CSL];
  wire         cs_default   = mode_reg[elec_pkg::MB_CSD];
  wire         ds_expdn     = mode_reg[elec_pkg::MB_DS_EXPDN];
  wire         inside_encl  = mode_reg[elec_pkg::MB_INENCL];
  wire         vmx_op       = mode_reg[elec_pkg::MB_VMXOP];
  wire         vmx_nonroot  = mode_reg[elec_pkg::MB_NONROOT];
  wire         hv_exit_ctl  = mode_reg[elec_pkg::MB_HV_CTL];
  wire         tx_active    = mode_reg[elec_pkg::MB_TXACT];
  wire [1:0]   priv_level   = mode_reg[elec_pkg::MB_PRIV_LO +: 2];
  wire         basic_cap    = caps_reg[elec_pkg::CB_BASIC];
  wire         oversub_cap  = caps_reg[elec_pkg::CB_OVERSUB];
  wire         feat_bad     = ~feat_reg[elec_pkg::FB_LOCK] |
                              ~feat_reg[elec_pkg::FB_ENABLE];

  // Upper accumulator half is kept for software but never selects a leaf
  wire [31:0]  leaf         = leaf_lo_reg;
  wire [63:0]  exit_bitmap  = {bitmap_hi_reg, bitmap_lo_reg};
  wire         wide_mode    = lma & cs_long;
  wire         addr64       = wide_mode;

  // Instruction and prefix decode
  wire [23:0]  opcode       = pwdata[23:0];
  wire         is_user_op   = opcode == elec_pkg::USER_OPCODE;
  wire         is_hyp_op    = opcode == elec_pkg::HYP_OPCODE;
  wire         pfx_bad      = pwdata[elec_pkg::IB_LOCK] | pwdata[elec_pkg::IB_OPSIZE] |
                              pwdata[elec_pkg::IB_REP] | pwdata[elec_pkg::IB_VEX];
  wire         pfx_ignored  = pwdata[elec_pkg::IB_SEGOVR] | pwdata[elec_pkg::IB_ADDRSZ] |
                              (pwdata[elec_pkg::IB_REX] & wide_mode);

  // Branch tracker selected by privilege level
  wire         is_user_priv = priv_level == elec_pkg::PRIV_USER;
  wire         bt_user_wait = mode_reg[elec_pkg::MB_BT_U_EN] & mode_reg[elec_pkg::MB_TRK_U];
  wire         bt_sup_wait  = mode_reg[elec_pkg::MB_BT_S_EN] & mode_reg[elec_pkg::MB_TRK_S];
  wire         awaiting_branch_marker = is_user_priv ? bt_user_wait : bt_sup_wait;
  wire         cp_hit       = awaiting_branch_marker &
                              ((leaf != elec_pkg::LEAF_RESUME) | task_sw | sys_mgmt |
                               ~basic_cap | ~is_user_priv);

  // User enclave checks
  wire         u_ud_mode    = ~prot_on | v86_mode | sys_mgmt;
  wire         u_ud_cap     = ~basic_cap;
  wire         u_ud_priv    = ~is_user_priv;
  wire         u_leaf_bad   = leaf >= elec_pkg::USER_LEAF_COUNT;
  wire         u_ctl_bad    = ~paging_on | ~native_fp_on;
  wire         u_16bit      = ~wide_mode & ~cs_default;
  wire         entry_leaf   = (leaf == elec_pkg::LEAF_ENTRY) | (leaf == elec_pkg::LEAF_RESUME);
  wire         inner_leaf   = (leaf == elec_pkg::LEAF_REPORT) | (leaf == elec_pkg::LEAF_KEY) |
                              (leaf == elec_pkg::LEAF_EXIT) | (leaf == elec_pkg::LEAF_ACCEPT) |
                              (leaf == elec_pkg::LEAF_PEXTEND) | (leaf == elec_pkg::LEAF_ACOPY);
  wire         encl_gp_in   = inside_encl & entry_leaf;
  wire         encl_gp_out  = ~inside_encl & inner_leaf;

  // Priority chain: only the first failing check reaches the result
  wire elec_pkg::elec_outcome_t u_outcome =
      pfx_bad                ? elec_pkg::OUT_UD       :
      tx_active              ? elec_pkg::OUT_TX_ABORT :
      cp_hit                 ? elec_pkg::OUT_CP       :
      (u_ud_mode | u_ud_cap) ? elec_pkg::OUT_UD       :
      task_sw                ? elec_pkg::OUT_NM       :
      u_ud_priv              ? elec_pkg::OUT_UD       :
      feat_bad               ? elec_pkg::OUT_GP       :
      u_leaf_bad             ? elec_pkg::OUT_GP       :
      u_ctl_bad              ? elec_pkg::OUT_GP       :
      u_16bit                ? elec_pkg::OUT_GP       :
      encl_gp_in             ? elec_pkg::OUT_GP       :
      encl_gp_out            ? elec_pkg::OUT_GP       :
                               elec_pkg::OUT_LEAF_FLOW;

  // Hypervisor enclave checks
  wire         h_ud_mode    = ~prot_on | v86_mode | sys_mgmt;
  wire         h_ud_cap     = ~oversub_cap;
  wire         h_ud_vmx     = ~vmx_op | (lma & ~cs_long);
  wire         h_ud_priv    = priv_level != elec_pkg::PRIV_KERNEL;
  wire         bm_bit       = (leaf > elec_pkg::BITMAP_LAST_LEAF) ? exit_bitmap[63] :
                              exit_bitmap[leaf[5:0]];
  wire         h_guest_ud   = vmx_nonroot & ~hv_exit_ctl;
  wire         h_guest_exit = vmx_nonroot & hv_exit_ctl & bm_bit;
  wire         h_leaf_bad   = leaf >= elec_pkg::HYP_LEAF_COUNT;
  wire         h_ds_bad     = ~wide_mode & ds_expdn;

  wire elec_pkg::elec_outcome_t h_outcome =
      pfx_bad                ? elec_pkg::OUT_UD       :
      tx_active              ? elec_pkg::OUT_TX_ABORT :
      (h_ud_mode | h_ud_cap) ? elec_pkg::OUT_UD       :
      h_ud_vmx               ? elec_pkg::OUT_UD       :
      h_ud_priv              ? elec_pkg::OUT_UD       :
      h_guest_ud             ? elec_pkg::OUT_UD       :
      h_guest_exit           ? elec_pkg::OUT_VM_EXIT  :
      feat_bad               ? elec_pkg::OUT_GP       :
      h_leaf_bad             ? elec_pkg::OUT_GP       :
      ~paging_on             ? elec_pkg::OUT_GP       :
      h_ds_bad               ? elec_pkg::OUT_GP       :
                               elec_pkg::OUT_LEAF_FLOW;

  wire elec_pkg::elec_outcome_t issue_outcome =
      is_user_op ? u_outcome :
      is_hyp_op  ? h_outcome : elec_pkg::OUT_NOT_MINE;
  wire         issue_gp     = issue_outcome == elec_pkg::OUT_GP;
  wire [31:0]  result_next  = {(issue_gp ? elec_pkg::GP_ERROR_CODE : 16'h0000), 7'h00,
                               is_hyp_op, pfx_ignored, addr64, wide_mode, issue_gp,
                               issue_outcome};

  // Bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access_start;
      pslverr_reg <= access_start & ~mapped;
      if (access_start) begin
        prdata_reg <= (pwrite || !mapped) ? 32'h0000_0000 : read_mux;
      end
    end
  end

  // State registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg      <= 32'h0000_0000;
      caps_reg      <= 32'h0000_0000;
      feat_reg      <= 32'h0000_0000;
      leaf_lo_reg   <= 32'h0000_0000;
      leaf_hi_reg   <= 32'h0000_0000;
      bitmap_lo_reg <= 32'h0000_0000;
      bitmap_hi_reg <= 32'h0000_0000;
    end else if (wr_done) begin
      if (sel_mode) mode_reg <= merge_bytes(mode_reg, pwdata, pstrb, elec_pkg::MODE_MASK);
      if (sel_caps) caps_reg <= merge_bytes(caps_reg, pwdata, pstrb, elec_pkg::CAPS_MASK);
      if (sel_feat) feat_reg <= merge_bytes(feat_reg, pwdata, pstrb, elec_pkg::FEAT_MASK);
      if (sel_leaf_lo) leaf_lo_reg <= merge_bytes(leaf_lo_reg, pwdata, pstrb, '1);
      if (sel_leaf_hi) leaf_hi_reg <= merge_bytes(leaf_hi_reg, pwdata, pstrb, '1);
      if (sel_bm_lo) bitmap_lo_reg <= merge_bytes(bitmap_lo_reg, pwdata, pstrb, '1);
      if (sel_bm_hi) bitmap_hi_reg <= merge_bytes(bitmap_hi_reg, pwdata, pstrb, '1);
    end
  end

  // Outcome of each issued instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg           <= 32'h0000_0000;
      outcome_reg          <= 4'h0;
      leaf_index_reg       <= 32'h0000_0000;
      outcome_valid_reg    <= 1'b0;
      leaf_flow_go_reg     <= 1'b0;
      tx_abort_reg         <= 1'b0;
      branch_violation_reg <= 1'b0;
      vm_exit_reg          <= 1'b0;
    end else begin
      outcome_valid_reg    <= issue_fire;
      leaf_flow_go_reg     <= issue_fire & (issue_outcome == elec_pkg::OUT_LEAF_FLOW);
      tx_abort_reg         <= issue_fire & (issue_outcome == elec_pkg::OUT_TX_ABORT);
      branch_violation_reg <= issue_fire & (issue_outcome == elec_pkg::OUT_CP);
      vm_exit_reg          <= issue_fire & (issue_outcome == elec_pkg::OUT_VM_EXIT);
      if (issue_fire) begin
        result_reg     <= result_next;
        outcome_reg    <= issue_outcome;
        leaf_index_reg <= leaf;
      end
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign outcome          = outcome_reg;
  assign outcome_valid    = outcome_valid_reg;
  assign leaf_flow_go     = leaf_flow_go_reg;
  assign leaf_index       = leaf_index_reg;
  assign tx_abort         = tx_abort_reg;
  assign branch_violation = branch_violation_reg;
  assign vm_exit          = vm_exit_reg;

endmodule

// >>> verification/elec_top_props.sv
// Checker for the enclave entry checker: APB timing and outcome pulses.
// Assumes it is bound to elec_top and sees only its ports.
`timescale 1ns/1ns
module elec_top_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  outcome,
  input wire logic        outcome_valid,
  input wire logic        leaf_flow_go,
  input wire logic [31:0] leaf_index,
  input wire logic        tx_abort,
  input wire logic        branch_violation,
  input wire logic        vm_exit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire issue_w = psel && penable && pready && pwrite && paddr == elec_pkg::OFS_ISSUE
                 && pstrb == 4'hf;
  wait_state_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  issue_answer_a: assert property (issue_w |=> outcome_valid)
    else $error("issue without outcome");
  valid_pulse_a: assert property (outcome_valid |=> !outcome_valid)
    else $error("outcome_valid not a pulse");
  outcome_hold_a: assert property (!outcome_valid |->
    $stable(outcome) && $stable(leaf_index))
    else $error("outcome changed between issues");
  flow_go_a: assert property (leaf_flow_go ==
    (outcome_valid && outcome == 4'(elec_pkg::OUT_LEAF_FLOW)))
    else $error("leaf_flow_go disagrees with outcome");
  tx_abort_a: assert property (tx_abort ==
    (outcome_valid && outcome == 4'(elec_pkg::OUT_TX_ABORT)))
    else $error("tx_abort disagrees with outcome");
  cp_flag_a: assert property (branch_violation ==
    (outcome_valid && outcome == 4'(elec_pkg::OUT_CP)))
    else $error("branch_violation disagrees with outcome");
  vm_exit_a: assert property (vm_exit ==
    (outcome_valid && outcome == 4'(elec_pkg::OUT_VM_EXIT)))
    else $error("vm_exit disagrees with outcome");
  prefix_ud_a: assert property (issue_w && pwdata[23:0] == elec_pkg::USER_OPCODE && |pwdata[27:24]
    |=> outcome == 4'(elec_pkg::OUT_UD))
    else $error("bad prefix not undefined");
endmodule
bind elec_top elec_top_props elec_top_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .outcome(outcome),
  .outcome_valid(outcome_valid), .leaf_flow_go(leaf_flow_go), .leaf_index(leaf_index),
  .tx_abort(tx_abort), .branch_violation(branch_violation), .vm_exit(vm_exit));

// >>> verification/test_elec_top.sv
// Self-checking bench for elec_top: APB master, reference model, outcome monitor.
// Assumes elec_pkg and the checker are compiled first.
`timescale 1ns/1ns
module test_elec_top;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, leaf_index;
  logic [3:0]  pstrb, outcome;
  logic        pready, pslverr, outcome_valid, leaf_flow_go, tx_abort, branch_violation, vm_exit;
  logic [31:0] md, cp, ft, lf, is, s, uo, ho, r, sp;
  logic [63:0] bm;
  logic [3:0]  q_out[$];
  logic [31:0] q_leaf[$];
  int          miscompares, compares;
  elec_top elec_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .outcome(outcome), .outcome_valid(outcome_valid),
    .leaf_flow_go(leaf_flow_go), .leaf_index(leaf_index), .tx_abort(tx_abort),
    .branch_violation(branch_violation), .vm_exit(vm_exit));
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input logic c, input string m);
    compares++;
    if (c !== 1'b1) begin
      miscompares++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Expected outcome of an issue from the state last written
  function automatic logic [3:0] model();
    logic u, w, tk;
    logic [1:0] pl;
    u = is[23:0] == elec_pkg::USER_OPCODE;
    pl = md[elec_pkg::MB_PRIV_LO +: 2];
    w = md[elec_pkg::MB_LMA] & md[elec_pkg::MB_CSL];
    tk = (pl == elec_pkg::PRIV_USER) ? md[elec_pkg::MB_BT_U_EN] & md[elec_pkg::MB_TRK_U]
                                     : md[elec_pkg::MB_BT_S_EN] & md[elec_pkg::MB_TRK_S];
    if (!u && is[23:0] != elec_pkg::HYP_OPCODE) return elec_pkg::OUT_NOT_MINE;
    if (|is[27:24]) return elec_pkg::OUT_UD;
    if (md[elec_pkg::MB_TXACT]) return elec_pkg::OUT_TX_ABORT;
    if (u && tk && (lf != elec_pkg::LEAF_RESUME || md[elec_pkg::MB_TSW] ||
        md[elec_pkg::MB_SYSMGMT] || !cp[elec_pkg::CB_BASIC] || pl != elec_pkg::PRIV_USER))
      return elec_pkg::OUT_CP;
    if (!md[elec_pkg::MB_PROT] || md[elec_pkg::MB_V86] || md[elec_pkg::MB_SYSMGMT] ||
        !cp[u ? elec_pkg::CB_BASIC : elec_pkg::CB_OVERSUB]) return elec_pkg::OUT_UD;
    if (u) begin
      if (md[elec_pkg::MB_TSW]) return elec_pkg::OUT_NM;
      if (pl != elec_pkg::PRIV_USER) return elec_pkg::OUT_UD;
    end else begin
      if (!md[elec_pkg::MB_VMXOP] || (md[elec_pkg::MB_LMA] && !md[elec_pkg::MB_CSL]) ||
          pl != elec_pkg::PRIV_KERNEL) return elec_pkg::OUT_UD;
      if (md[elec_pkg::MB_NONROOT] && !md[elec_pkg::MB_HV_CTL]) return elec_pkg::OUT_UD;
      if (md[elec_pkg::MB_NONROOT] && bm[(lf > elec_pkg::BITMAP_LAST_LEAF) ? 6'h3f : lf[5:0]])
        return elec_pkg::OUT_VM_EXIT;
    end
    if (!ft[elec_pkg::FB_LOCK] || !ft[elec_pkg::FB_ENABLE]) return elec_pkg::OUT_GP;
    if (lf >= (u ? elec_pkg::USER_LEAF_COUNT : elec_pkg::HYP_LEAF_COUNT)) return elec_pkg::OUT_GP;
    if (!md[elec_pkg::MB_PAGING] || (u && !md[elec_pkg::MB_NATFP])) return elec_pkg::OUT_GP;
    if (!w && (u ? !md[elec_pkg::MB_CSD] : md[elec_pkg::MB_DS_EXPDN])) return elec_pkg::OUT_GP;
    if (u && md[elec_pkg::MB_INENCL] ==
        (lf == elec_pkg::LEAF_ENTRY || lf == elec_pkg::LEAF_RESUME)) return elec_pkg::OUT_GP;
    return elec_pkg::OUT_LEAF_FLOW;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1, a, d, q, e);
  endtask
  task automatic run(input logic [31:0] m, c, f, l, h, input logic [63:0] b, input logic [31:0] i);
    logic [31:0] q;
    logic e;
    logic [3:0] eo;
    logic w;
    md = m;
    cp = c;
    ft = f;
    lf = l;
    bm = b;
    is = i;
    w = m[elec_pkg::MB_LMA] & m[elec_pkg::MB_CSL];
    wr(elec_pkg::OFS_MODE_STATE, m);
    wr(elec_pkg::OFS_CAPS, c);
    wr(elec_pkg::OFS_FEATURE_CTL, f);
    wr(elec_pkg::OFS_LEAF_LO, l);
    wr(elec_pkg::OFS_LEAF_HI, h);
    wr(elec_pkg::OFS_BITMAP_LO, b[31:0]);
    wr(elec_pkg::OFS_BITMAP_HI, b[63:32]);
    eo = model();
    q_out.push_back(eo);
    q_leaf.push_back(l);
    wr(elec_pkg::OFS_ISSUE, i);
    apb(0, elec_pkg::OFS_RESULT, 32'h0000_0000, q, e);
    chk(q[3:0] === eo, "result outcome");
    chk(q[31:16] === elec_pkg::GP_ERROR_CODE, "error code");
    chk(q[5] === w, "wide indicator");
    chk(q[6] === w, "wide addressing");
    chk(q[4] === (eo == elec_pkg::OUT_GP), "error code flag");
    chk(q[7] === (i[elec_pkg::IB_SEGOVR] | i[elec_pkg::IB_ADDRSZ] |
                  (i[elec_pkg::IB_REX] & w)), "ignored prefix");
    chk(q[8] === (i[23:0] == elec_pkg::HYP_OPCODE), "hypervisor flag");
  endtask
  // Monitor: each outcome pulse takes the oldest note
  always @(posedge pclk) begin
    if (outcome_valid === 1'b1) begin
      if (q_out.size() == 0) chk(0, "unexpected outcome");
      else begin
        chk(outcome === q_out.pop_front(), "outcome");
        chk(leaf_index === q_leaf.pop_front(), "leaf index");
      end
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    chk(0, "watchdog expired");
    end_of_test();
  end
  initial begin
    logic [31:0] q;
    logic e;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    s = 32'h4952_eebe;
    uo = {8'h00, elec_pkg::USER_OPCODE};
    ho = {8'h00, elec_pkg::HYP_OPCODE};
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h0fc, 32'h0000_0000, q, e);
    chk(e === 1'b1 && q === 32'h0000_0000, "unmapped read");
    run(32'h0003_04c7, 32'h21, 32'h3, 32'h4, 32'h0, 64'h0, uo);
    run(32'h0003_04c7, 32'h21, 32'h3, 32'h2, 32'h0, 64'h0, uo);
    run(32'h0003_0147, 32'h21, 32'h3, 32'h3, 32'hffff_ffff, 64'h0, uo | 32'h7000_0000);
    run(32'h0000_38c7, 32'h21, 32'h3, 32'h50, 32'h0, 64'h8000_0000_0000_0000, ho);
    run(32'h0000_18c7, 32'h21, 32'h3, 32'h1, 32'h0, 64'h0, ho);
    run(32'h0017_04c7, 32'h21, 32'h3, 32'h4, 32'h0, 64'h0, uo);
    run(32'h0003_44c7, 32'h21, 32'h3, 32'h4, 32'h0, 64'h0, uo);
    run(32'h0000_08c7, 32'h01, 32'h3, 32'h0, 32'h0, 64'h0, ho);
    for (int k = 0; k < 120; k++) begin
      r = xs();
      sp = xs() & xs() & xs() & xs();
      is = r[2:0] == 3'h7 ? 32'h000f_0100 : (r[0] ? uo : ho);
      md = (r[0] ? 32'h0003_00c7 : 32'h0000_08c7) | (r & 32'h0000_3400);
      lf = (r[30] & r[29]) ? xs() : {28'h0, r[7:4]};
      run(md ^ (sp & elec_pkg::MODE_MASK), 32'h21 ^ (sp & elec_pkg::CAPS_MASK),
          32'h3 ^ (sp >> 8 & elec_pkg::FEAT_MASK), lf, xs(), {xs(), xs()},
          is | (sp & 32'h7f00_0000));
    end
    repeat (5) @(posedge pclk);
    chk(q_out.size() == 0, "outcome missing");
    end_of_test();
  end
endmodule
